// File: hdl/lam_pkg.sv
// Shared constants, register map and carrier types of the limit alert monitor
package lam_pkg;

  // Register port widths
  localparam int unsigned PTR_W  = 8;
  localparam int unsigned DATA_W = 16;

  // Register pointers
  localparam logic [7:0] PTR_DEVICE_CONFIG    = 8'h00;
  localparam logic [7:0] PTR_DIAG_STATUS      = 8'h0B;
  localparam logic [7:0] PTR_CUR_UNDER_THR    = 8'h0C;
  localparam logic [7:0] PTR_CUR_OVER_THR     = 8'h0D;
  localparam logic [7:0] PTR_BUS_OVER_THR     = 8'h0E;
  localparam logic [7:0] PTR_BUS_UNDER_THR    = 8'h0F;
  localparam logic [7:0] PTR_HEAT_OVER_THR    = 8'h10;
  localparam logic [7:0] PTR_PWR_OVER_THR     = 8'h11;

  // Reset values
  localparam logic [15:0] RST_CUR_UNDER_THR   = 16'h8000;
  localparam logic [15:0] RST_CUR_OVER_THR    = 16'h7FFF;
  localparam logic [15:0] RST_BUS_OVER_THR    = 16'h7FFF;
  localparam logic [15:0] RST_BUS_UNDER_THR   = 16'h0000;
  localparam logic [15:0] RST_HEAT_OVER_THR   = 16'hFFFF;
  localparam logic [15:0] RST_PWR_OVER_THR    = 16'h7FFF;
  localparam logic [14:0] RST_CONFIG_MISC     = 15'h0000;

  // Device configuration field
  localparam int unsigned CFG_SOFT_RESET_BIT  = 15;

  // Diagnostic status fields
  localparam int unsigned DIAG_HOLD_EN_BIT    = 15;
  localparam int unsigned DIAG_READY_EN_BIT   = 14;
  localparam int unsigned DIAG_AVG_EN_BIT     = 13;
  localparam int unsigned DIAG_HIGH_SEL_BIT   = 12;
  localparam int unsigned DIAG_ENERGY_WR_BIT  = 11;
  localparam int unsigned DIAG_CHARGE_WR_BIT  = 10;
  localparam int unsigned DIAG_MATH_OVF_BIT   = 9;
  localparam int unsigned DIAG_HEAT_OVER_BIT  = 7;
  localparam int unsigned DIAG_CUR_OVER_BIT   = 6;
  localparam int unsigned DIAG_CUR_UNDER_BIT  = 5;
  localparam int unsigned DIAG_BUS_OVER_BIT   = 4;
  localparam int unsigned DIAG_BUS_UNDER_BIT  = 3;
  localparam int unsigned DIAG_PWR_OVER_BIT   = 2;
  localparam int unsigned DIAG_CONV_RDY_BIT   = 1;
  localparam int unsigned DIAG_TRIM_OK_BIT    = 0;

  // One set of measurement results
  typedef struct packed {
    logic        valid;
    logic [15:0] current;
    logic [15:0] bus;
    logic [15:0] heat;
    logic [23:0] power;
  } lam_meas_s;

  // Six programmable thresholds
  typedef struct packed {
    logic [15:0] cur_under;
    logic [15:0] cur_over;
    logic [15:0] bus_over;
    logic [15:0] bus_under;
    logic [15:0] heat_over;
    logic [15:0] pwr_over;
  } lam_limits_s;

  // Out-of-range conditions
  typedef struct packed {
    logic cur_under;
    logic cur_over;
    logic bus_over;
    logic bus_under;
    logic heat_over;
    logic pwr_over;
  } lam_cond_s;

endpackage

// File: hdl/lam_limit_check.sv
// Threshold comparators for current, bus voltage, die heat and power
`timescale 1ns/1ps
module lam_limit_check
  import lam_pkg::*;
(
  // Results and thresholds
  input  lam_meas_s   meas_i,
  input  lam_limits_s limits_i,
  // Conditions
  output lam_cond_s   cond_o
);

  // Negative readings count as zero for positive-only quantities
  function automatic logic [15:0] lam_pos(input logic [15:0] x);
    lam_pos = x[15] ? 16'h0000 : x;
  endfunction

  always_comb begin
    cond_o.cur_under = $signed(meas_i.current) < $signed(limits_i.cur_under);
    cond_o.cur_over  = $signed(meas_i.current) > $signed(limits_i.cur_over);
    cond_o.pwr_over  = $signed(meas_i.power[23:8]) > $signed(limits_i.pwr_over);
    cond_o.bus_over  = lam_pos(meas_i.bus) > limits_i.bus_over;
    cond_o.bus_under = lam_pos(meas_i.bus) < limits_i.bus_under;
    cond_o.heat_over = lam_pos(meas_i.heat) > limits_i.heat_over;
  end

endmodule // lam_limit_check

// File: hdl/lam_alert_pin.sv
// Open-drain alert pin driver with selectable polarity
`timescale 1ns/1ps
module lam_alert_pin
  import lam_pkg::*;
(
  // Clock and reset
  input  logic clk_i,
  input  logic rst_i,
  // Control
  input  logic active_i,
  input  logic high_sel_i,
  // Pin
  input  logic alert_pin_i,
  output logic alert_pin_o,
  output logic alert_pin_oe_n_o
);

  typedef struct packed {
    logic oe_n;
  } lam_pin_s;

  lam_pin_s s;
  lam_pin_s next_s;

  // Pull low when active-low asserted, or when active-high idle
  always_comb begin
    next_s.oe_n = ~(high_sel_i ? ~active_i : active_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s.oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign alert_pin_o      = 1'b0;
  assign alert_pin_oe_n_o = s.oe_n;

endmodule // lam_alert_pin

// File: hdl/lam_monitor.sv
// Limit alert monitor: thresholds, diagnostic status and alert line control
`timescale 1ns/1ps
module lam_monitor
  import lam_pkg::*;
(
  // Clock and reset
  input  logic              clk_i,
  input  logic              rst_i,
  // Register port from the serial interface
  input  logic              reg_wr_i,
  input  logic              reg_rd_i,
  input  logic [PTR_W-1:0]  reg_ptr_i,
  input  logic [DATA_W-1:0] reg_wdata_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  // Measurement engine
  input  lam_meas_s         meas_single_i,
  input  lam_meas_s         meas_avg_i,
  input  logic              cycle_done_i,
  input  logic              adc_cfg_wr_i,
  input  logic              adc_cfg_shutdown_i,
  // Engine health events
  input  logic              math_ovf_i,
  input  logic              energy_ovf_i,
  input  logic              charge_ovf_i,
  input  logic              trim_ok_i,
  // Alert pin
  input  logic              alert_pin_i,
  output logic              alert_pin_o,
  output logic              alert_pin_oe_n_o
);

  typedef struct packed {
    lam_limits_s limits;
    lam_cond_s   cond;
    logic [14:0] cfg_misc;
    logic        hold_en;
    logic        ready_en;
    logic        avg_en;
    logic        high_sel;
    logic        math_ovf;
    logic        energy_wrap;
    logic        charge_wrap;
    logic        conv_ready;
    logic [15:0] rdata;
  } lam_state_s;

  lam_state_s s;
  lam_state_s next_s;

  // Default register contents
  function automatic lam_state_s lam_defaults();
    lam_state_s d;
    d                  = '0;
    d.limits.cur_under = RST_CUR_UNDER_THR;
    d.limits.cur_over  = RST_CUR_OVER_THR;
    d.limits.bus_over  = RST_BUS_OVER_THR;
    d.limits.bus_under = RST_BUS_UNDER_THR;
    d.limits.heat_over = RST_HEAT_OVER_THR;
    d.limits.pwr_over  = RST_PWR_OVER_THR;
    d.cfg_misc         = RST_CONFIG_MISC;
    return d;
  endfunction

  // Diagnostic status word
  function automatic logic [15:0] lam_diag_word(input lam_state_s st, input logic trim_ok);
    logic [15:0] w;
    w                     = '0;
    w[DIAG_HOLD_EN_BIT]   = st.hold_en;
    w[DIAG_READY_EN_BIT]  = st.ready_en;
    w[DIAG_AVG_EN_BIT]    = st.avg_en;
    w[DIAG_HIGH_SEL_BIT]  = st.high_sel;
    w[DIAG_ENERGY_WR_BIT] = st.energy_wrap;
    w[DIAG_CHARGE_WR_BIT] = st.charge_wrap;
    w[DIAG_MATH_OVF_BIT]  = st.math_ovf;
    w[DIAG_HEAT_OVER_BIT] = st.cond.heat_over;
    w[DIAG_CUR_OVER_BIT]  = st.cond.cur_over;
    w[DIAG_CUR_UNDER_BIT] = st.cond.cur_under;
    w[DIAG_BUS_OVER_BIT]  = st.cond.bus_over;
    w[DIAG_BUS_UNDER_BIT] = st.cond.bus_under;
    w[DIAG_PWR_OVER_BIT]  = st.cond.pwr_over;
    w[DIAG_CONV_RDY_BIT]  = st.conv_ready;
    w[DIAG_TRIM_OK_BIT]   = trim_ok;
    return w;
  endfunction

  // Register read mux
  function automatic logic [15:0] lam_read(input lam_state_s st, input logic [7:0] ptr, input logic trim_ok);
    logic [15:0] v;
    v = '0;
    unique case (ptr)
      PTR_DEVICE_CONFIG: v = {1'b0, st.cfg_misc};
      PTR_DIAG_STATUS:   v = lam_diag_word(st, trim_ok);
      PTR_CUR_UNDER_THR: v = st.limits.cur_under;
      PTR_CUR_OVER_THR:  v = st.limits.cur_over;
      PTR_BUS_OVER_THR:  v = st.limits.bus_over;
      PTR_BUS_UNDER_THR: v = st.limits.bus_under;
      PTR_HEAT_OVER_THR: v = st.limits.heat_over;
      PTR_PWR_OVER_THR:  v = st.limits.pwr_over;
      default:           v = '0;
    endcase
    return v;
  endfunction

  lam_meas_s   meas_sel;
  lam_cond_s   cond_new;
  logic        diag_rd;
  logic        soft_rst;
  logic        ready_clr;
  logic        line_active;

  // Averaged or single results feed the comparators
  assign meas_sel = s.avg_en ? meas_avg_i : meas_single_i;

  lam_limit_check u_check (
    .meas_i   (meas_sel),
    .limits_i (s.limits),
    .cond_o   (cond_new)
  );

  assign diag_rd   = reg_rd_i && (reg_ptr_i == PTR_DIAG_STATUS);
  assign soft_rst  = reg_wr_i && (reg_ptr_i == PTR_DEVICE_CONFIG) && reg_wdata_i[CFG_SOFT_RESET_BIT];
  assign ready_clr = diag_rd || (adc_cfg_wr_i && !adc_cfg_shutdown_i);

  always_comb begin
    next_s = s;

    // Condition flags
    if (s.hold_en) begin
      if (diag_rd) begin
        next_s.cond = '0;
      end
      if (meas_sel.valid) begin
        next_s.cond = (diag_rd ? lam_cond_s'('0) : s.cond) | cond_new;
      end
    end else if (meas_sel.valid) begin
      next_s.cond = cond_new;
    end

    // Conversion ready: set wins over clear
    if (ready_clr) begin
      next_s.conv_ready = 1'b0;
    end
    if (cycle_done_i) begin
      next_s.conv_ready = 1'b1;
    end

    // Sticky health flags, cleared by a status read
    next_s.math_ovf    = math_ovf_i   | (s.math_ovf    & ~diag_rd);
    next_s.energy_wrap = energy_ovf_i | (s.energy_wrap & ~diag_rd);
    next_s.charge_wrap = charge_ovf_i | (s.charge_wrap & ~diag_rd);

    // Read data captured with the request
    if (reg_rd_i) begin
      next_s.rdata = lam_read(s, reg_ptr_i, trim_ok_i);
    end

    // Register writes
    if (reg_wr_i) begin
      unique case (reg_ptr_i)
        PTR_DEVICE_CONFIG: next_s.cfg_misc = reg_wdata_i[14:0];
        PTR_DIAG_STATUS: begin
          next_s.hold_en  = reg_wdata_i[DIAG_HOLD_EN_BIT];
          next_s.ready_en = reg_wdata_i[DIAG_READY_EN_BIT];
          next_s.avg_en   = reg_wdata_i[DIAG_AVG_EN_BIT];
          next_s.high_sel = reg_wdata_i[DIAG_HIGH_SEL_BIT];
        end
        PTR_CUR_UNDER_THR: next_s.limits.cur_under = reg_wdata_i;
        PTR_CUR_OVER_THR:  next_s.limits.cur_over  = reg_wdata_i;
        PTR_BUS_OVER_THR:  next_s.limits.bus_over  = reg_wdata_i;
        PTR_BUS_UNDER_THR: next_s.limits.bus_under = reg_wdata_i;
        PTR_HEAT_OVER_THR: next_s.limits.heat_over = reg_wdata_i;
        PTR_PWR_OVER_THR:  next_s.limits.pwr_over  = reg_wdata_i;
        default: ;
      endcase
    end

    // Soft reset returns every register to its default
    if (soft_rst) begin
      next_s = lam_defaults();
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= lam_defaults();
    end else begin
      s <= next_s;
    end
  end

  // Only limit conditions and conversion events reach the line
  assign line_active = (|s.cond) || (s.ready_en && s.conv_ready);

  lam_alert_pin u_pin (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .active_i         (line_active),
    .high_sel_i       (s.high_sel),
    .alert_pin_i      (alert_pin_i),
    .alert_pin_o      (alert_pin_o),
    .alert_pin_oe_n_o (alert_pin_oe_n_o)
  );

  assign reg_rdata_o = s.rdata;

endmodule // lam_monitor

// File: bench/lam_host.sv
// Host side model: pulled-up alert line seen by the controller
`timescale 1ns/1ps
module lam_host
  import lam_pkg::*;
(
  // Device pin
  input  wire logic alert_pin_o,
  input  wire logic alert_pin_oe_n_o,
  // Resolved line
  output logic      alert_line_o
);
  // Pull-up holds the line high unless the device pulls low
  assign alert_line_o = alert_pin_oe_n_o ? 1'b1 : alert_pin_o;
endmodule // lam_host

// File: bench/lam_chk_monitor.sv
// Port assertions of the limit alert monitor
`timescale 1ns/1ps
module lam_chk
  import lam_pkg::*;
(
  // Clock and reset
  input logic              clk_i,
  input logic              rst_i,
  // Register port
  input logic              reg_wr_i,
  input logic              reg_rd_i,
  input logic [PTR_W-1:0]  reg_ptr_i,
  input logic [DATA_W-1:0] reg_wdata_i,
  input logic [DATA_W-1:0] reg_rdata_o,
  // Engine and pin
  input logic              cycle_done_i,
  input logic              adc_cfg_wr_i,
  input logic              adc_cfg_shutdown_i,
  input logic              trim_ok_i,
  input logic              alert_pin_o,
  input logic              alert_pin_oe_n_o
);
  logic rdg;
  logic sft;
  assign rdg = reg_rd_i && reg_ptr_i == PTR_DIAG_STATUS;
  assign sft = reg_wr_i && reg_ptr_i == PTR_DEVICE_CONFIG && reg_wdata_i[CFG_SOFT_RESET_BIT];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_read_data_stands: assert property (
    !reg_rd_i && !sft |=> $stable(reg_rdata_o)) else $error("read data moved");
  a_unmapped_reads_zero: assert property (
    reg_rd_i && reg_ptr_i > PTR_PWR_OVER_THR |=> reg_rdata_o == 16'h0000) else $error("unmapped read");
  a_pin_drives_low: assert property (
    alert_pin_o == 1'b0) else $error("pin drives high");
  a_ready_sets_flag: assert property (
    cycle_done_i && !sft ##1 rdg |=> reg_rdata_o[DIAG_CONV_RDY_BIT]) else $error("ready flag missing");
  a_read_clears_ready: assert property (
    rdg && !cycle_done_i ##1 rdg |=> !reg_rdata_o[DIAG_CONV_RDY_BIT]) else $error("ready kept on read");
  a_cfg_clears_ready: assert property (
    adc_cfg_wr_i && !adc_cfg_shutdown_i && !cycle_done_i ##1 rdg |=> !reg_rdata_o[DIAG_CONV_RDY_BIT])
    else $error("ready kept");
  a_trim_shows_live: assert property (
    rdg && trim_ok_i == $past(trim_ok_i) && !$past(rst_i) |=> reg_rdata_o[DIAG_TRIM_OK_BIT] == $past(trim_ok_i))
    else $error("trim bit wrong");
  a_soft_clears_ctl: assert property (
    sft ##1 !reg_wr_i ##1 rdg |=> reg_rdata_o[15:12] == 4'h0) else $error("soft reset kept controls");
  a_pin_reset_idle: assert property (
    $past(rst_i) |-> alert_pin_oe_n_o) else $error("pin driven after reset");
  a_soft_releases_pin: assert property (
    sft |-> ##2 alert_pin_oe_n_o) else $error("pin driven after soft reset");
  c_ready_read: cover property (cycle_done_i ##1 rdg);
  c_soft_reset: cover property (sft);
  c_cfg_clear: cover property (adc_cfg_wr_i && !adc_cfg_shutdown_i);
  c_pin_driven: cover property (!alert_pin_oe_n_o);
endmodule // lam_chk

bind lam_monitor lam_chk lam_chk_i (.clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_ptr_i, .reg_wdata_i,
  .reg_rdata_o, .cycle_done_i, .adc_cfg_wr_i, .adc_cfg_shutdown_i, .trim_ok_i, .alert_pin_o,
  .alert_pin_oe_n_o);

// File: bench/tb_top.sv
// Self-checking testbench of the limit alert monitor
`timescale 1ns/1ps
module tb_top;
  import lam_pkg::*;
  logic        clk_i, rst_i, reg_wr_i, reg_rd_i, cycle_done_i, adc_cfg_wr_i;
  logic        adc_cfg_shutdown_i, math_ovf_i, energy_ovf_i, charge_ovf_i;
  logic        trim_ok_i, alert_pin_o, alert_pin_oe_n_o, line;
  logic [7:0]  reg_ptr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, d, d2;
  lam_meas_s   meas_single_i, meas_avg_i;
  int          fail_count, check_count, cyc;

  lam_monitor lam_monitor_i (.clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_ptr_i, .reg_wdata_i,
    .reg_rdata_o, .meas_single_i, .meas_avg_i, .cycle_done_i, .adc_cfg_wr_i, .adc_cfg_shutdown_i,
    .math_ovf_i, .energy_ovf_i, .charge_ovf_i, .trim_ok_i, .alert_pin_i(line), .alert_pin_o,
    .alert_pin_oe_n_o);
  lam_host lam_host_i (.alert_pin_o, .alert_pin_oe_n_o, .alert_line_o(line));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task tick();
    @(posedge clk_i);
    #1;
  endtask

  // Engine event inputs by index
  localparam int EV_DONE   = 0;
  localparam int EV_CFG    = 1;
  localparam int EV_MATH   = 2;
  localparam int EV_ENERGY = 3;
  localparam int EV_CHARGE = 4;

  task ev(input int k, input logic v);
    case (k)
      EV_DONE:   cycle_done_i = v;
      EV_CFG:    adc_cfg_wr_i = v;
      EV_MATH:   math_ovf_i = v;
      EV_ENERGY: energy_ovf_i = v;
      default:   charge_ovf_i = v;
    endcase
  endtask

  task pulse(input int k);
    ev(k, 1'b1);
    tick();
    ev(k, 1'b0);
  endtask

  task wr(input logic [7:0] p, input logic [15:0] v);
    reg_wr_i = 1'b1;
    reg_ptr_i = p;
    reg_wdata_i = v;
    tick();
    reg_wr_i = 1'b0;
    tick();
  endtask

  task rd(input logic [7:0] p);
    reg_rd_i = 1'b1;
    reg_ptr_i = p;
    tick();
    d = reg_rdata_o;
    reg_rd_i = 1'b0;
    tick();
  endtask

  // Two status reads on consecutive edges
  task rd2();
    reg_rd_i = 1'b1;
    reg_ptr_i = PTR_DIAG_STATUS;
    tick();
    d = reg_rdata_o;
    tick();
    d2 = reg_rdata_o;
    reg_rd_i = 1'b0;
    tick();
  endtask

  task chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
      fail_count++;
    end
  endtask

  task pin(input logic e);
    tick();
    tick();
    chk(line, e);
  endtask

  task meas(input logic avg, input logic [15:0] c);
    lam_meas_s m;
    m = '0;
    m.valid = 1'b1;
    m.current = c;
    if (avg) meas_avg_i = m;
    else meas_single_i = m;
    tick();
    meas_avg_i.valid = 1'b0;
    meas_single_i.valid = 1'b0;
    tick();
  endtask

  task t_defaults();
    logic [15:0] rv [6];
    rv = '{16'h8000, 16'h7FFF, 16'h7FFF, 16'h0000, 16'hFFFF, 16'h7FFF};
    for (int i = 0; i < 6; i++) begin
      rd(PTR_CUR_UNDER_THR + 8'(i));
      chk(d, rv[i]);
    end
  endtask

  task t_regs();
    t_defaults();
    for (int i = 0; i < 6; i++) wr(PTR_CUR_UNDER_THR + 8'(i), 16'h1230 + 16'(i));
    for (int i = 0; i < 6; i++) begin
      rd(PTR_CUR_UNDER_THR + 8'(i));
      chk(d, 16'h1230 + 16'(i));
    end
    rd(8'h20);
    chk(d, 16'h0000);
    wr(PTR_DEVICE_CONFIG, 16'h7ABC);
    rd(PTR_DEVICE_CONFIG);
    chk(d, 16'h7ABC);
    wr(PTR_DIAG_STATUS, 16'hF000);
    wr(PTR_DEVICE_CONFIG, 16'h8000);
    rd(PTR_DIAG_STATUS);
    chk(d[15:12], 4'h0);
    rd(PTR_DEVICE_CONFIG);
    chk(d, 16'h0000);
    t_defaults();
  endtask

  task t_over();
    wr(PTR_CUR_OVER_THR, 16'h0100);
    meas(1'b0, 16'h0200);
    pin(1'b0);
    rd(PTR_DIAG_STATUS);
    chk(d[6], 1'b1);
    meas(1'b0, 16'hFF00);
    pin(1'b1);
  endtask

  task t_hold();
    wr(PTR_DIAG_STATUS, 16'h8000);
    meas(1'b0, 16'h0200);
    meas(1'b0, 16'h0000);
    pin(1'b0);
    rd(PTR_DIAG_STATUS);
    chk(d[6], 1'b1);
    pin(1'b1);
    wr(PTR_DIAG_STATUS, 16'h0000);
  endtask

  task t_ready();
    pulse(EV_DONE);
    rd2();
    chk(d[1], 1'b1);
    chk(d2[1], 1'b0);
    chk(line, 1'b1);
    wr(PTR_DIAG_STATUS, 16'h5000);
    pin(1'b0);
    pulse(EV_DONE);
    pin(1'b1);
    adc_cfg_shutdown_i = 1'b1;
    pulse(EV_CFG);
    pin(1'b1);
    adc_cfg_shutdown_i = 1'b0;
    pulse(EV_CFG);
    rd(PTR_DIAG_STATUS);
    chk(d[1], 1'b0);
    meas(1'b0, 16'h0200);
    pin(1'b1);
    meas(1'b0, 16'h0000);
    pin(1'b0);
    wr(PTR_DIAG_STATUS, 16'h0000);
  endtask

  task t_avg();
    wr(PTR_DIAG_STATUS, 16'h2000);
    meas(1'b0, 16'h0200);
    pin(1'b1);
    meas(1'b1, 16'h0200);
    pin(1'b0);
    meas(1'b1, 16'h0000);
    pin(1'b1);
  endtask

  task t_health();
    pulse(EV_MATH);
    pulse(EV_ENERGY);
    pulse(EV_CHARGE);
    pin(1'b1);
    rd(PTR_DIAG_STATUS);
    chk(d[11:9], 3'h7);
    chk(d[0], 1'b1);
    trim_ok_i = 1'b0;
    rd(PTR_DIAG_STATUS);
    chk(d[11:0], 12'h000);
  endtask

  // Bus, heat, power and under-current limits, negative readings included
  task t_limits();
    lam_meas_s m;
    m = '0;
    wr(PTR_DIAG_STATUS, 16'h0000);
    wr(PTR_BUS_OVER_THR, 16'h4000);
    wr(PTR_BUS_UNDER_THR, 16'h1000);
    wr(PTR_HEAT_OVER_THR, 16'h0200);
    wr(PTR_PWR_OVER_THR, 16'h0100);
    wr(PTR_CUR_UNDER_THR, 16'hFF00);
    m.valid = 1'b1;
    m.current = 16'hFE00;
    m.bus = 16'h5000;
    m.heat = 16'h0300;
    m.power = 24'h020000;
    meas_single_i = m;
    tick();
    meas_single_i.valid = 1'b0;
    rd(PTR_DIAG_STATUS);
    chk(d[7:2], 6'h2D);
    chk(line, 1'b0);
    m.current = 16'h0000;
    m.bus = 16'h8000;
    m.heat = 16'hF000;
    m.power = 24'h000000;
    meas_single_i = m;
    tick();
    meas_single_i.valid = 1'b0;
    rd(PTR_DIAG_STATUS);
    chk(d[7:2], 6'h02);
  endtask

  task end_sim();
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    rst_i = 1'b1;
    {reg_wr_i, reg_rd_i, cycle_done_i, adc_cfg_wr_i, adc_cfg_shutdown_i} = '0;
    {math_ovf_i, energy_ovf_i, charge_ovf_i, reg_ptr_i, reg_wdata_i} = '0;
    trim_ok_i = 1'b1;
    meas_single_i = '0;
    meas_avg_i = '0;
    repeat (8) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    t_regs();
    t_over();
    t_hold();
    t_ready();
    t_avg();
    t_health();
    t_limits();
    end_sim();
  end
endmodule // tb_top
